// ---- core/spcp_pkg.sv ----
/*
 * spcp_pkg: constants and carrier types for the spi command port.
 * assumes: included before the fifo and the port module.
 */
package spcp_pkg;
	// =========================================================
	// framing
	localparam int          SPCP_WORD_BITS  = 8;
	localparam logic [7:0]  SPCP_READY_CODE = 8'hEA;
	localparam logic [7:0]  SPCP_QUERY_CODE = 8'h00;
	localparam logic [7:0]  SPCP_IDLE_FILL  = 8'h00;
	localparam int          SPCP_FIFO_DEPTH = 4;
	// =========================================================
	// link timing
	localparam int          SPCP_SCK_MAX_KHZ = 4000;
	localparam int          SPCP_MCLK_KHZ    = 100000;
	localparam int          SPCP_MCLK_PER_SCK = SPCP_MCLK_KHZ / SPCP_SCK_MAX_KHZ;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} spcp_byte_t;

	typedef enum logic [2:0] {
		SPCP_RDY_IDLE = 3'b001,
		SPCP_RDY_PUSH = 3'b010,
		SPCP_RDY_DONE = 3'b100
	} spcp_rdy_t;
endpackage : spcp_pkg

// ---- core/spcp_port.sv ----
/*
 * spcp_port: byte-wide spi slave command port with a response fifo.
 * assumes: serial_clock_in is the master's clock, stopped outside frames;
 * MCLK_I is the system clock; cross traffic uses toggles and a held word;
 * the select leads the first rising edge by at least three system clocks.
 */
// What this block does
// - eight-bit words, msb first, clock idles low, sample on rising edge, clock <=4MHz
// - slave only; nothing moves unless the master clocks it
// - every received byte is answered with one byte shifted out in the same transfer
// - ready code 0xEA queued once after each reset when default transmitter
// - slave select is active low; transfers happen only while it is low
`timescale 1ns/10ps

// =========================================================
// fifo
module spcp_fifo
	import spcp_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)(
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0]   wp;
		logic [AW:0]   rp;
	} spcp_fifo_st_t;
	spcp_fifo_st_t         st_r;
	spcp_fifo_st_t         st_nxt;
	logic [WIDTH-1:0]      mem_r [DEPTH];
	logic                  full;
	logic                  empty;

	assign full        = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
	assign empty       = (st_r.wp == st_r.rp);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem_r[st_r.rp[AW-1:0]];

	always_comb
	begin
		st_nxt = st_r;
		if (in_valid_i && !full)
			st_nxt.wp = st_r.wp + 1'b1;
		if (out_ready_i && !empty)
			st_nxt.rp = st_r.rp + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
		if (in_valid_i && !full)
			mem_r[st_r.wp[AW-1:0]] <= in_data_i;
	end
endmodule : spcp_fifo

// =========================================================
// top
module spcp_port
	import spcp_pkg::*;
(
	input  wire logic       MCLK_I,
	input  wire logic       RST_N_I,
	input  wire logic       DEFAULT_TX_I,
	input  wire logic       SERIAL_CLOCK_IN_I,
	input  wire logic       SS_N_I,
	input  wire logic       MOSI_I,
	output logic            MISO_O,
	output logic            MISO_OE_O,
	input  wire logic       RESP_VALID_I,
	output logic            RESP_READY_O,
	input  wire logic [7:0] RESP_DATA_I,
	output logic            CMD_VALID_O,
	output logic [7:0]      CMD_DATA_O,
	output logic            QUERY_O
);
	// =========================================================
	// system domain state
	typedef struct packed {
		spcp_rdy_t  rdy;
		logic [1:0] ss_sync;
		logic [1:0] rx_tgl_sync;
		logic       rx_tgl_seen;
		logic [1:0] ack_sync;
		logic       ack_seen;
		logic       ld_full;
		logic [7:0] ld_data;
		logic       cmd_valid;
		logic [7:0] cmd_data;
		logic       query;
	} spcp_sys_t;
	spcp_sys_t  sys_r;
	spcp_sys_t  sys_nxt;

	logic       fifo_in_valid;
	logic       fifo_in_ready;
	logic [7:0] fifo_in_data;
	logic       fifo_out_valid;
	logic       fifo_out_ready;
	logic [7:0] fifo_out_data;

	// link domain signals
	logic [2:0] bit_cnt_r;
	logic [2:0] tx_cnt_r;
	logic       later_r;
	logic [7:0] rx_sh_r;
	logic [7:0] rx_word_r;
	logic       rx_tgl_r;
	logic       ack_tgl_r;
	logic [7:0] rx_next;
	logic [7:0] tx_word;
	logic       load_ok;

	// ready code has priority into the fifo, once only
	always_comb
	begin
		fifo_in_valid = RESP_VALID_I;
		fifo_in_data  = RESP_DATA_I;
		if (sys_r.rdy == SPCP_RDY_PUSH)
		begin
			fifo_in_valid = 1'b1;
			fifo_in_data  = SPCP_READY_CODE;
		end
	end
	assign RESP_READY_O   = fifo_in_ready && (sys_r.rdy != SPCP_RDY_PUSH);
	// the held word only changes while the select has been seen idle
	assign fifo_out_ready = !sys_r.ld_full && (sys_r.ss_sync == 2'h3);

	spcp_fifo #(
		.WIDTH (SPCP_WORD_BITS),
		.DEPTH (SPCP_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (MCLK_I),
		.rst_n_i     (RST_N_I),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_in_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data)
	);

	always_comb
	begin
		sys_nxt             = sys_r;
		sys_nxt.ss_sync     = {sys_r.ss_sync[0], SS_N_I};
		sys_nxt.rx_tgl_sync = {sys_r.rx_tgl_sync[0], rx_tgl_r};
		sys_nxt.ack_sync    = {sys_r.ack_sync[0], ack_tgl_r};
		sys_nxt.cmd_valid   = 1'b0;
		sys_nxt.query       = 1'b0;
		unique case (sys_r.rdy)
			SPCP_RDY_IDLE: sys_nxt.rdy = DEFAULT_TX_I ? SPCP_RDY_PUSH : SPCP_RDY_DONE;
			SPCP_RDY_PUSH: if (fifo_in_ready) sys_nxt.rdy = SPCP_RDY_DONE;
			SPCP_RDY_DONE: sys_nxt.rdy = SPCP_RDY_DONE;
			default:       sys_nxt.rdy = SPCP_RDY_DONE;
		endcase
		// word captured on the link; rx_word_r is stable until the next word's toggle
		if (sys_r.rx_tgl_sync[1] != sys_r.rx_tgl_seen)
		begin
			sys_nxt.rx_tgl_seen = sys_r.rx_tgl_sync[1];
			if (rx_word_r == SPCP_QUERY_CODE)
				sys_nxt.query = 1'b1;
			else
			begin
				sys_nxt.cmd_valid = 1'b1;
				sys_nxt.cmd_data  = rx_word_r;
			end
		end
		// the link has shifted the held word out
		if (sys_r.ack_sync[1] != sys_r.ack_seen)
		begin
			sys_nxt.ack_seen = sys_r.ack_sync[1];
			sys_nxt.ld_full  = 1'b0;
		end
		// hand the next response word to the link while the select is idle
		if (fifo_out_ready && fifo_out_valid)
		begin
			sys_nxt.ld_full = 1'b1;
			sys_nxt.ld_data = fifo_out_data;
		end
	end

	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			sys_r         <= '0;
			sys_r.rdy     <= SPCP_RDY_IDLE;
			sys_r.ss_sync <= 2'b11;
		end
		else
			sys_r <= sys_nxt;
	end

	assign CMD_VALID_O = sys_r.cmd_valid;
	assign CMD_DATA_O  = sys_r.cmd_data;
	assign QUERY_O     = sys_r.query;

	// =========================================================
	// link domain: runs only on master edges
	assign rx_next = {rx_sh_r[6:0], MOSI_I};

	always_ff @(posedge SERIAL_CLOCK_IN_I or posedge SS_N_I)
	begin
		if (SS_N_I)
		begin
			bit_cnt_r <= 3'h0;
			rx_sh_r   <= 8'h00;
		end
		else
		begin
			rx_sh_r   <= rx_next;
			bit_cnt_r <= bit_cnt_r + 3'h1;
		end
	end

	// toggles outlive frames; the link clock is stopped in reset, so only an
	// asynchronous clear from the system reset can reach them
	always_ff @(posedge SERIAL_CLOCK_IN_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rx_word_r <= 8'h00;
			rx_tgl_r  <= 1'b0;
			ack_tgl_r <= 1'b0;
		end
		else if (bit_cnt_r == 3'h7)
		begin
			rx_word_r <= rx_next;
			rx_tgl_r  <= !rx_tgl_r;
			if (load_ok)
				ack_tgl_r <= !ack_tgl_r;
		end
	end

	// the miso bit index moves on falling edges, so the master's rising edge sees the bit settled
	always_ff @(negedge SERIAL_CLOCK_IN_I or posedge SS_N_I)
	begin
		if (SS_N_I)
		begin
			tx_cnt_r <= 3'h0;
			later_r  <= 1'b0;
		end
		else
		begin
			tx_cnt_r <= bit_cnt_r;
			if (bit_cnt_r == 3'h0)
				later_r <= 1'b1;
		end
	end

	// held word goes to the first byte of a frame only; the system side leaves it
	// alone while the select is low, so the link may read it without a synchroniser
	assign load_ok   = !later_r && sys_r.ld_full;
	assign tx_word   = load_ok ? sys_r.ld_data : SPCP_IDLE_FILL;
	assign MISO_O    = tx_word[3'h7 - tx_cnt_r];
	assign MISO_OE_O = !SS_N_I;
endmodule : spcp_port

// ---- tb/spcp_master_model.sv ----
/* spcp_master_model: mode 0 spi master.
   assumes: caller spaces frames. */
`timescale 1ns/10ps
module spcp_master_model (
	output logic      sck_o,
	output logic      ss_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial
	begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// ======
	// frame of n bits, fewer than 8 aborts
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		// off the system clock edge, then a lead the port needs to settle its word
		#3 ss_n_o = 1'b0;
		#60;
		for (int i = 7; i > 7 - n; i--)
		begin
			mosi_o = tx[i];
			#6 sck_o = 1'b1;
			rx[i] = miso_i;
			#6 sck_o = 1'b0;
		end
		#6 ss_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#200;
	endtask : xfer
endmodule : spcp_master_model

// ---- tb/spcp_port_properties.sv ----
/* spcp_port_props: pin checks of the command port.
   assumes: bound to spcp_port, one clock domain. */
`timescale 1ns/10ps
module spcp_port_props (
	input wire logic       MCLK_I,
	input wire logic       RST_N_I,
	input wire logic       DEFAULT_TX_I,
	input wire logic       SS_N_I,
	input wire logic       MISO_OE_O,
	input wire logic       RESP_READY_O,
	input wire logic       CMD_VALID_O,
	input wire logic [7:0] CMD_DATA_O,
	input wire logic       QUERY_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// ======
	// checks
	a_oe_off: assert property (SS_N_I && $past(SS_N_I) |-> !MISO_OE_O)
		else $error("miso driven idle");
	a_oe_on: assert property (!SS_N_I && !$past(SS_N_I) |-> MISO_OE_O)
		else $error("miso undriven");
	a_cmd_pulse: assert property (CMD_VALID_O |=> !CMD_VALID_O)
		else $error("long cmd pulse");
	a_query_pulse: assert property (QUERY_O |=> !QUERY_O)
		else $error("long query pulse");
	a_data_hold: assert property ($changed(CMD_DATA_O) |-> CMD_VALID_O || QUERY_O)
		else $error("cmd data moved");
	a_ready_code: assert property ($rose(RST_N_I) && DEFAULT_TX_I |-> ##[1:3] !RESP_READY_O)
		else $error("no ready push");
	a_quiet_link: assert property (SS_N_I [*8] |=> !CMD_VALID_O && !QUERY_O)
		else $error("output unframed");
	c_cmd: cover property (CMD_VALID_O);
	c_query: cover property (QUERY_O);
	c_full: cover property ($fell(RESP_READY_O) && SS_N_I);
endmodule : spcp_port_props

bind spcp_port spcp_port_props u_props (.MCLK_I, .RST_N_I, .DEFAULT_TX_I, .SS_N_I,
	.MISO_OE_O, .RESP_READY_O, .CMD_VALID_O, .CMD_DATA_O, .QUERY_O);

// ---- tb/spcp_port_test.sv ----
/* spcp_port_test: bench of the command port.
   assumes: spcp_pkg compiled first. */
`timescale 1ns/10ps
module spcp_port_test;
	import spcp_pkg::*;
	logic       clk = 0, rst_n = 0, rv = 0, default_tx = 1;
	logic [7:0] rd = 8'h00, cd, rx;
	logic       rrdy, miso, oe, cv, qv, sck, ss_n, mosi;
	int         mismatches = 0, n_checks = 0, n_cmd = 0, n_qry = 0;
	always #5 clk = ~clk;
	spcp_port u_dut (.MCLK_I(clk), .RST_N_I(rst_n), .DEFAULT_TX_I(default_tx),
		.SERIAL_CLOCK_IN_I(sck), .SS_N_I(ss_n), .MOSI_I(mosi), .MISO_O(miso),
		.MISO_OE_O(oe), .RESP_VALID_I(rv), .RESP_READY_O(rrdy), .RESP_DATA_I(rd),
		.CMD_VALID_O(cv), .CMD_DATA_O(cd), .QUERY_O(qv));
	spcp_master_model u_mst (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi),
		.miso_i(oe ? miso : ~miso));
	always @(posedge clk)
	begin
		n_cmd <= n_cmd + cv;
		n_qry <= n_qry + qv;
	end
	// ======
	// helpers
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task sx(input logic [7:0] tx, input int n = 8);
		u_mst.xfer(tx, n, rx);
		repeat (8) @(posedge clk);
	endtask : sx
	task t_ready;
		sx(8'h00);
		chk("first", SPCP_READY_CODE, rx);
		sx(8'h00);
		chk("second", SPCP_IDLE_FILL, rx);
		chk("queries", 8'h02, 8'(n_qry));
		chk("cmds", 8'h00, 8'(n_cmd));
	endtask : t_ready
	task t_cmd;
		sx(8'hA5);
		chk("cmd reply", SPCP_IDLE_FILL, rx);
		chk("cmd", 8'hA5, cd);
		chk("cmds", 8'h01, 8'(n_cmd));
	endtask : t_cmd
	// the word held for the link adds one place to the queue
	task t_fifo;
		for (int i = 0; i < 6; i++)
		begin
			rd <= 8'h30 + i[7:0];
			rv <= 1'b1;
			@(negedge clk);
			chk("ready", {7'h00, i < SPCP_FIFO_DEPTH + 1}, rrdy);
			@(posedge clk);
		end
		rv <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			sx(8'h00);
			chk("reply", (i < SPCP_FIFO_DEPTH + 1) ? 8'h30 + i[7:0] : SPCP_IDLE_FILL, rx);
		end
	endtask : t_fifo
	task t_abort;
		sx(8'hFF, 3);
		sx(8'h3C);
		chk("after abort", 8'h3C, cd);
	endtask : t_abort
	task t_no_ready;
		default_tx <= 1'b0;
		rst_n      <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		sx(8'h00);
		chk("no ready code", SPCP_IDLE_FILL, rx);
	endtask : t_no_ready
	task summarize;
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		t_ready();
		t_cmd();
		t_fifo();
		t_abort();
		t_no_ready();
		summarize();
	end
	initial
	begin
		#50000;
		mismatches++;
		summarize();
	end
endmodule : spcp_port_test
